//--- hdl/sram_byte_write_mask.sv
// Purpose: Write port of a burst-of-two SRAM with per-lane write masks.
// Assumes: Beat edges arrive as pin levels and are sampled on clk_i.
// Notes:   Array is modelled on-chip; read port shown for completeness.
//
// Function
// R1 - 8-bit: both nibble masks low write all
// R2 - 8-bit: mask0 low only writes bits 3:0
// R3 - 8-bit: mask1 low only writes bits 7:4
// R4 - 18-bit: both masks low write all bits
// R5 - 18-bit: mask0 low only writes bits 8:0
// R6 - 18-bit: mask1 low only writes bits 17:9
// R7 - 8/18-bit: both masks high write nothing
// R8 - 9-bit: low mask writes, high mask suppresses
// R9 - 36-bit: all masks low write all
// R10 - 36-bit: mask0 alone writes bits 8:0
// R11 - 36-bit: mask1 alone writes bits 17:9
// R12 - 36-bit: mask2 alone writes bits 26:18
// R13 - 36-bit: mask3 alone writes bits 35:27
// R14 - 36-bit: all masks high alter nothing
// R15 - Powers up deselected, read outputs undriven
// R16 - Burst words go to A+0, A+1
// R17 - Data and masks taken on both clocks
// R18 - Read data launched on output clock edges
// R19 - Controller parks clocks equal when stopped
// R20 - Each beat masked by its own masks
// R21 - Controller starts write with load, select low
// R22 - Controller gives words one cycle after address
// R23 - Each lane mask gates own lane independently
// R24 - Posted writes still honour lane masks
`timescale 1ns/1ns
`default_nettype none
module sram_byte_write_mask
  import sram_mask_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF
)
(
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Input beat clocks, true and complementary, as pin levels.
  input  wire logic              kclk_i,
  input  wire logic              kclk_n_i,
  // Output timing clocks and single clock strap.
  input  wire logic              cclk_i,
  input  wire logic              cclk_n_i,
  input  wire logic              single_clock_i,
  // Control and address.
  input  wire logic              load_strobe_n_i,
  input  wire logic              read_sel_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // Write data and lane masks.
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [lane_count(DATA_W)-1:0] lane_write_mask_n_i,
  // Read data.
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   rdata_oe_o
);

  // ---------------------------------------------------------------------
  // Derived geometry
  // ---------------------------------------------------------------------
  localparam int LANES = lane_count(DATA_W);
  localparam int LW    = lane_width(DATA_W);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // Two stages for every pin; first stage feeds only the second.
  localparam int PW = 6 + 1 + ADDR_W + DATA_W + LANES;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1_reg;
  logic [PW-1:0] pin_s2_reg;
  logic [2:0]    sync_fill_reg;  // Stages that already hold pin values.
  assign pin_raw = {kclk_i, kclk_n_i, cclk_i, cclk_n_i, single_clock_i,
                    load_strobe_n_i, read_sel_i, addr_i, wdata_i,
                    lane_write_mask_n_i};

  // Synchroniser flops.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      sync_fill_reg <= 3'h0;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      sync_fill_reg <= {sync_fill_reg[1:0], 1'b1};
    end
  end

  // Split synchronised bundle.
  logic              k_s;
  logic              kn_s;
  logic              c_s;
  logic              cn_s;
  logic              strap_s;
  logic              ld_n_s;
  logic              rsel_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [LANES-1:0]  mask_n_s;
  assign {k_s, kn_s, c_s, cn_s, strap_s, ld_n_s, rsel_s, addr_s, data_s,
          mask_n_s} = pin_s2_reg;

  // ---------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------
  // Previous levels of the four clocks.
  logic [3:0] clk_prev_reg;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      clk_prev_reg <= 4'h0;
    else
      clk_prev_reg <= {k_s, kn_s, c_s, cn_s};
  end

  // One-cycle pulses on each rising edge, held off until the history
  // holds real levels, so a pin idling high gives no false edge.
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  assign k_rise  = k_s  & ~clk_prev_reg[3] & sync_fill_reg[2];
  assign kn_rise = kn_s & ~clk_prev_reg[2] & sync_fill_reg[2];
  assign c_rise  = c_s  & ~clk_prev_reg[1] & sync_fill_reg[2];
  assign cn_rise = cn_s & ~clk_prev_reg[0] & sync_fill_reg[2];

  // Strap caught once the synchroniser holds the real pin; not alterable.
  logic strap_reg;
  logic strap_done_reg;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg && sync_fill_reg[1])
    begin
      strap_reg      <= strap_s;
      strap_done_reg <= 1'b1;
    end
  end

  // Output launch edges follow the strap.
  logic out_rise_a;
  logic out_rise_b;
  assign out_rise_a = strap_reg ? k_rise  : c_rise;  // R18
  assign out_rise_b = strap_reg ? kn_rise : cn_rise; // R18

  // ---------------------------------------------------------------------
  // Write sequencer
  // ---------------------------------------------------------------------
  // The load cycle latches the address; beats come on the next K and K#.
  seq_state_type     wstate_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic              wr_start;
  logic              wr_start_pend_reg;
  assign wr_start = k_rise && !ld_n_s && !rsel_s;

  // Sequencer state.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wstate_reg <= ST_IDLE;
    else
    begin
      case (wstate_reg)
        ST_IDLE:
          if (wr_start)
            wstate_reg <= ST_BEAT0;
        ST_BEAT0:
          if (k_rise)
            wstate_reg <= ST_BEAT1;
        ST_BEAT1:
          if (kn_rise)
            wstate_reg <= wr_start_pend_reg ? ST_BEAT0 : ST_IDLE;
        default:
          wstate_reg <= ST_IDLE;
      endcase
    end
  end

  // A new load at beat-0's K edge chains into the next burst.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wr_start_pend_reg <= 1'b0;
    else if (wstate_reg == ST_BEAT0 && k_rise)
      wr_start_pend_reg <= !ld_n_s && !rsel_s;
    else if (wstate_reg != ST_BEAT1)
      wr_start_pend_reg <= 1'b0;
  end

  // Latched start address, including chained loads.
  logic [ADDR_W-1:0] naddr_reg;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      waddr_reg <= '0;
      naddr_reg <= '0;
    end
    else
    begin
      if (wstate_reg == ST_IDLE && wr_start)
        waddr_reg <= addr_s;
      else if (wstate_reg == ST_BEAT1 && kn_rise)
        waddr_reg <= naddr_reg;
      if (wstate_reg == ST_BEAT0 && k_rise)
        naddr_reg <= addr_s;
    end
  end

  // ---------------------------------------------------------------------
  // Beat capture and lane decode
  // ---------------------------------------------------------------------
  // Data and masks are taken together on each beat's edge.
  logic              beat_take;
  logic              beat_second;
  assign beat_take   = (wstate_reg == ST_BEAT0 && k_rise) ||
                       (wstate_reg == ST_BEAT1 && kn_rise); // R17
  assign beat_second = (wstate_reg == ST_BEAT1);

  // Each active-low mask independently enables its own lane only.
  logic [LANES-1:0] lane_en;
  assign lane_en = ~mask_n_s; // R1 R2 R3 R4 R5 R6 R7 R8 R20 R23

  // Per-lane effect in the widest variant, one lane per mask.
  // R9 R10 R11 R12 R13 R14

  // Posted write register: the beat waits here for an array slot.
  logic              post_valid_reg;
  logic [ADDR_W-1:0] post_addr_reg;
  logic [DATA_W-1:0] post_data_reg;
  logic [LANES-1:0]  post_lane_reg;
  logic              rd_busy;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      post_valid_reg <= 1'b0;
      post_addr_reg  <= '0;
      post_data_reg  <= '0;
      post_lane_reg  <= '0;
    end
    else if (beat_take)
    begin
      post_valid_reg <= 1'b1;
      post_addr_reg  <= beat_second ? waddr_reg + ADDR_W'(BEAT1_OFS)
                                    : waddr_reg + ADDR_W'(BEAT0_OFS); // R16
      post_data_reg  <= data_s;
      post_lane_reg  <= lane_en; // R24
    end
    else if (!rd_busy)
      post_valid_reg <= 1'b0;
  end

  // Commit when no read uses the array this cycle.
  logic commit;
  assign commit = post_valid_reg && !rd_busy;

  // ---------------------------------------------------------------------
  // Read sequencer
  // ---------------------------------------------------------------------
  logic              rd_start;
  logic [ADDR_W-1:0] raddr_reg;
  logic [1:0]        rcnt_reg;
  assign rd_start = k_rise && !ld_n_s && rsel_s;
  assign rd_busy  = rd_start;

  // Read address and launch count.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      raddr_reg <= '0;
      rcnt_reg  <= 2'h0;
    end
    else if (rd_start)
    begin
      raddr_reg <= addr_s;
      rcnt_reg  <= 2'(BURST_LEN);
    end
    else if (rcnt_reg != 2'h0 && (out_rise_a || out_rise_b))
    begin
      rcnt_reg  <= rcnt_reg - 2'h1;
      raddr_reg <= raddr_reg + ADDR_W'(BEAT1_OFS); // R16
    end
  end

  // Array.
  logic [DATA_W-1:0] mem_rdata;
  sram_lane_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LW     (LW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (commit),
    .waddr_i (post_addr_reg),
    .wdata_i (post_data_reg),
    .wlane_i (post_lane_reg),
    .raddr_i (raddr_reg),
    .rdata_o (mem_rdata)
  );

  // Output register: deselected from reset until a read launches.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o    <= '0;
      rdata_oe_o <= RD_OE_RST; // R15
    end
    else if (rcnt_reg != 2'h0 && (out_rise_a || out_rise_b))
    begin
      rdata_o    <= mem_rdata; // R18
      rdata_oe_o <= 1'b1;
    end
    else if (rcnt_reg == 2'h0 && out_rise_a)
      rdata_oe_o <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_beat;
    beat_take;
  endsequence

  a_beat_posts:     assert property (s_beat |=> post_valid_reg) // R17
    else $error("beat not posted");
  a_lanes_follow:   assert property (s_beat |=> post_lane_reg == $past(~mask_n_s)) // R23
    else $error("lane enables differ from masks");
  a_masked_none:    assert property // R7
    ((s_beat and (&mask_n_s)) |=> post_lane_reg == '0)
    else $error("all-high masks wrote a lane");
  a_second_addr:    assert property (beat_take && beat_second |=> post_addr_reg == $past(waddr_reg) + ADDR_W'(1)) // R16
    else $error("second word address wrong");
  a_first_addr:     assert property (beat_take && !beat_second |=> post_addr_reg == $past(waddr_reg)) // R16
    else $error("first word address wrong");
  a_commit_lanes:   assert property // R24
    (post_valid_reg && rd_busy && !beat_take |=> $stable(post_lane_reg))
    else $error("posted lanes changed");
  a_post_wait:      assert property (post_valid_reg && rd_busy && !beat_take |=> post_valid_reg) // R24
    else $error("posted write lost");
  a_idle_quiet:     assert property (rcnt_reg == 2'h0 && out_rise_a |=> !rdata_oe_o) // R15
    else $error("outputs driven while deselected");

endmodule
`default_nettype wire

//--- hdl/sram_mask_pkg.sv
// Purpose: Shared constants for the lane-masked burst SRAM write port.
// Assumes: One system clock; beat edges arrive as pins and are synchronised.
// Notes:   Widths select the variant; lane widths follow from the width.
package sram_mask_pkg;

  // ---------------------------------------------------------------------
  // Geometry defaults
  // ---------------------------------------------------------------------
  // Default data width of one beat, the widest variant.
  localparam int DATA_W_DEF   = 36;
  // Default address width of the array model.
  localparam int ADDR_W_DEF   = 6;
  // Lane width for the nibble variant.
  localparam int NIBBLE_W     = 4;
  // Lane width for the byte-lane variants.
  localparam int LANE_W       = 9;
  // Burst length in words.
  localparam int BURST_LEN    = 2;
  // Offset of the first burst word from the latched address.
  localparam int BEAT0_OFS    = 0;
  // Offset of the second burst word from the latched address.
  localparam int BEAT1_OFS    = 1;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  // Read data enable after reset: outputs not driven.
  localparam logic RD_OE_RST  = 1'b0;

  // ---------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BEAT0,
    ST_BEAT1
  } seq_state_type;

  // Number of lanes for a given data width.
  function automatic int lane_count(input int dw);
    if (dw == 8)
      return 2;
    else if (dw == 9)
      return 1;
    else
      return dw / LANE_W;
  endfunction

  // Width of one lane for a given data width.
  function automatic int lane_width(input int dw);
    if (dw == 8)
      return NIBBLE_W;
    else
      return LANE_W;
  endfunction

endpackage

//--- hdl/sram_lane_mem.sv
// Purpose: Array with per-lane write enables and a registered read port.
// Assumes: One write and one read per clock.
// Notes:   Unwritten lanes keep their stored bits.
`timescale 1ns/1ns
`default_nettype none
module sram_lane_mem
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 6,
  parameter int LANES  = 4,
  parameter int LW     = 9
)
(
  // Clock.
  input  wire logic              clk_i,
  // Write port.
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [LANES-1:0]  wlane_i,
  // Read port.
  input  wire logic [ADDR_W-1:0] raddr_i,
  output logic      [DATA_W-1:0] rdata_o
);

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  // The array itself; no reset, as real SRAM has none.
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // One write process walks the lanes, so a high mask leaves its lane
  // alone; a single process keeps the array to one writer.
  always_ff @(posedge clk_i)
  begin
    for (int g = 0; g < LANES; g++)
      if (we_i && wlane_i[g])
        mem[waddr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
  end

  // Read data comes out of a register.
  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem[raddr_i];
  end

endmodule
`default_nettype wire

//--- test/sram_ctrl_model.sv
// Purpose: Behavioural memory controller driving the write and read pins.
// Assumes: Pin clocks are slow against clk_i, six clocks per level.
// Notes:   Idle fields show inverted values so stale data never helps.
`timescale 1ns/1ns
`default_nettype none
module sram_ctrl_model
#(
  parameter int DW = 36,
  parameter int AW = 6,
  parameter int LN = 4
)
(
  // Clock.
  input  wire logic          clk_i,
  // Beat clocks, true and complementary.
  output var  logic          kclk_o,
  output var  logic          kclk_n_o,
  // Control, address, data and masks.
  output var  logic          load_strobe_n_o,
  output var  logic          read_sel_o,
  output var  logic [AW-1:0] addr_o,
  output var  logic [DW-1:0] wdata_o,
  output var  logic [LN-1:0] mask_n_o
);
  // ---------------------------------------------------------------
  // Pins at time zero, clocks parked at equal levels.
  // ---------------------------------------------------------------
  initial
  begin
    kclk_o          = 1'h0;
    kclk_n_o        = 1'h0;
    load_strobe_n_o = 1'h1;
    read_sel_o      = 1'h0;
    addr_o          = '0;
    wdata_o         = '0;
    mask_n_o        = '1;
  end

  // One half period: fields settle two clocks before the clock rise and
  // hold four clocks after, so the block's synchronisers see them stable.
  task automatic half(input logic krise, input logic ld_n,
                      input logic rd, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, input logic [LN-1:0] m,
                      input logic dv);
    @(posedge clk_i);
    load_strobe_n_o <= ld_n;
    read_sel_o      <= rd;
    addr_o          <= ld_n ? ~addr_o : a;
    wdata_o         <= dv ? d : ~wdata_o;
    mask_n_o        <= dv ? m : ~mask_n_o;
    repeat (2) @(posedge clk_i);
    kclk_o   <= krise;
    kclk_n_o <= !krise;
    repeat (3) @(posedge clk_i);
  endtask

  // Load on a true rise, data one cycle later on the true then the
  // complementary rise.
  task automatic write_burst(input logic [AW-1:0] a,
                             input logic [DW-1:0] d0,
                             input logic [LN-1:0] m0,
                             input logic [DW-1:0] d1,
                             input logic [LN-1:0] m1);
    half(1'h1, 1'h0, 1'h0, a, '0, '0, 1'h0);
    half(1'h0, 1'h1, 1'h0, a, '0, '0, 1'h0);
    half(1'h1, 1'h1, 1'h0, a, d0, m0, 1'h1);
    half(1'h0, 1'h1, 1'h0, a, d1, m1, 1'h1);
  endtask

  // Read load, then idle halves long enough for both words to leave.
  task automatic read_burst(input logic [AW-1:0] a);
    half(1'h1, 1'h0, 1'h1, a, '0, '0, 1'h0);
    repeat (3)
    begin
      half(1'h0, 1'h1, 1'h0, a, '0, '0, 1'h0);
      half(1'h1, 1'h1, 1'h0, a, '0, '0, 1'h0);
    end
    half(1'h0, 1'h1, 1'h0, a, '0, '0, 1'h0);
  endtask

  // Stop the clocks at equal levels for a quick restart.
  task automatic park();
    @(posedge clk_i);
    kclk_o   <= 1'h0;
    kclk_n_o <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- test/sram_byte_write_mask_test.sv
// Purpose: Self-checking bench for all four data widths of the write port.
// Assumes: Some widths use the single clock strap, others run C from K.
// Notes:   A shadow array predicts every read; a monitor pops and compares.
`timescale 1ns/1ns
`default_nettype none
module sram_lane_harness
#(
  parameter int DW = 36,
  parameter int AW = 6,
  parameter bit SC = 1'b1
)
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Results.
  output var  logic done_o,
  output var  int   errs_o,
  output var  int   cmps_o
);
  // Lane geometry worked out here, apart from the design's helpers.
  localparam int LW = (DW == 8) ? 4 : 9;
  localparam int LN = (DW == 8) ? 2 : ((DW == 9) ? 1 : DW / 9);
  wire logic          kclk;
  wire logic          kclk_n;
  wire logic          load_n;
  wire logic          rd_sel;
  wire logic [AW-1:0] addr;
  wire logic [DW-1:0] wdata;
  wire logic [LN-1:0] mask_n;
  wire logic [DW-1:0] rdata;
  wire logic          rdata_oe;
  logic      [DW-1:0] shadow [2**AW];
  logic      [DW-1:0] exp_q [$];
  logic      [31:0]   rng;

  sram_ctrl_model #(.DW(DW), .AW(AW), .LN(LN)) i_ctrl
  (
    .clk_i(clk_i), .kclk_o(kclk), .kclk_n_o(kclk_n),
    .load_strobe_n_o(load_n), .read_sel_o(rd_sel), .addr_o(addr),
    .wdata_o(wdata), .mask_n_o(mask_n)
  );

  // With SC the C clocks are held high for single clock operation;
  // otherwise C and C# follow K and K# with zero skew.
  sram_byte_write_mask #(.DATA_W(DW), .ADDR_W(AW)) i_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .kclk_i(kclk), .kclk_n_i(kclk_n),
    .cclk_i(SC ? 1'h1 : kclk), .cclk_n_i(SC ? 1'h1 : kclk_n),
    .single_clock_i(SC),
    .load_strobe_n_i(load_n), .read_sel_i(rd_sel), .addr_i(addr),
    .wdata_i(wdata), .lane_write_mask_n_i(mask_n),
    .rdata_o(rdata), .rdata_oe_o(rdata_oe)
  );

  // Xorshift source; 64 bits are built and cut to the data width.
  function automatic logic [DW-1:0] rnd();
    logic [63:0] w;
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    w[31:0] = rng;
    w[63:32] = ~rng ^ (rng << 7);
    return w[DW-1:0];
  endfunction

  // Lanes whose mask is low take the new bits, the rest keep old ones.
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
                                          input logic [DW-1:0] n,
                                          input logic [LN-1:0] m);
    for (int b = 0; b < DW; b++)
      if (!m[b / LW])
        o[b] = n[b];
    return o;
  endfunction

  task automatic chk_word(input string what, input logic [DW-1:0] e,
                          input logic [DW-1:0] g);
    cmps_o++;
    if (g !== e)
    begin
      errs_o++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_flag(input string what, input logic e, input logic g);
    cmps_o++;
    if (g !== e)
    begin
      errs_o++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [LN-1:0] m0,
                    input logic [LN-1:0] m1);
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;
    d0 = rnd();
    d1 = rnd();
    shadow[a] = merge(shadow[a], d0, m0);
    shadow[a + AW'(1)] = merge(shadow[a + AW'(1)], d1, m1);
    i_ctrl.write_burst(a, d0, m0, d1, m1);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    exp_q.push_back(shadow[a]);
    exp_q.push_back(shadow[a + AW'(1)]);
    i_ctrl.read_burst(a);
  endtask

  // Any word shown with no read pending is a mismatch too.
  task automatic take();
    if (exp_q.size() == 0)
      chk_flag("unrequested read", 1'h0, rdata_oe);
    else
      chk_word("read word", exp_q.pop_front(), rdata);
  endtask

  // ---------------------------------------------------------------
  // Monitor: mid-word sampling on falling edges, away from updates.
  // ---------------------------------------------------------------
  always
  begin
    @(negedge clk_i iff rdata_oe === 1'h1);
    repeat (2) @(negedge clk_i);
    take();
    repeat (6) @(negedge clk_i);
    take();
    while (rdata_oe === 1'h1)
      @(negedge clk_i);
  end

  // ---------------------------------------------------------------
  // Stimulus: reset state, full fill, then every mask combination.
  // ---------------------------------------------------------------
  initial
  begin
    logic [AW-1:0] a;
    logic [LN-1:0] m;
    done_o = 1'h0;
    errs_o = 0;
    cmps_o = 0;
    rng = 32'h0000_4b02;
    @(negedge rst_i);
    repeat (4) @(negedge clk_i);
    chk_flag("read enable", 1'h0, rdata_oe);
    chk_word("idle read data", '0, rdata);
    for (int i = 0; i < 2**AW - 1; i += 2)
      wr(AW'(i), '0, '0);
    rd('0);
    rd(AW'(2**AW - 3));
    $display("width %0d: fill test done", DW);
    for (int i = 0; i < 2**LN; i++)
    begin
      m = LN'(i);
      void'(rnd());
      a = AW'(rng % (2**AW - 1));
      wr(a, m, m);
      wr(a, m, ~m);
      rd(a);
    end
    i_ctrl.park();
    repeat (20) @(negedge clk_i);
    chk_flag("reads outstanding", 1'h0, exp_q.size() != 0);
    $display("width %0d: mask sweep done", DW);
    done_o = 1'h1;
  end
endmodule

module sram_byte_write_mask_test
  import sram_mask_pkg::*;
;
  localparam int WIDTHS [4] = '{8, 9, 18, 36};
  logic       clk;
  logic       rst;
  wire logic [3:0] done;
  int         errs [4];
  int         cmps [4];
  int         fail_count;
  int         cmp_count;

  // 25 MHz clock; reset held for four cycles.
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst = 1'h1;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
  end

  // One harness per data width, all running side by side; the 8 and 18
  // bit ones use the single clock strap, the 9 and 36 bit ones C clocks.
  for (genvar g = 0; g < 4; g++)
  begin : g_width
    sram_lane_harness #(.DW(WIDTHS[g]), .AW(ADDR_W_DEF),
                        .SC(g % 2 == 0)) i_harness
    (
      .clk_i(clk), .rst_i(rst), .done_o(done[g]),
      .errs_o(errs[g]), .cmps_o(cmps[g])
    );
  end

  task automatic final_report();
    for (int i = 0; i < 4; i++)
    begin
      fail_count += errs[i];
      cmp_count += cmps[i];
    end
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    wait (done === 4'hf);
    final_report();
  end

  // Roughly eight times the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    final_report();
  end
endmodule
`default_nettype wire
